// file: dsm_regs.svh
// Notes on behaviour
// (R1) Two test flags at bits 12 and 13 of status zero, updated by tests.
// (R2) Status one reachable at native address and legacy alias address.
// (R3) Compat on: alias write of shift field sign-extends into temp two.
// (R4) Compat on: legacy shift-by-field instructions use temp two count.
// (R5) Compat on: any temp two load copies low five bits to field.
// (R6) Compat off: field ignored, alias and temp two writes independent.
// (R7) Write turning compat on with field update sign-extends as if on.
// (R8) Loop flag at bit 15, reset 0, meaningful only in compat mode; repeatPass and the count decrement ignore compat.
// (R9) Block-repeat instruction at address phase sets loop flag.
// (R10) Last loop instruction decode: flag and counter positive repeat.
// (R11) Flag clears one cycle after counter reaches zero, same cycle if written zero.
// (R12) Far branch or far call clears flag; other flow changes do not.
// (R13) Bit set/clear and status one writes set or clear the flag.
// (R14) Flag saved and restored with status one on interrupt and return.
// (R15) Write turning compat on with flag update uses new compat state.
// (R16) Software clears loop flag before or while leaving compat mode.
// (R17) Software pads 0, 2 or 3 instructions before reading the flag.
// (R18) Software spaces flag changes 5 or 6 cycles from last instruction.
// (R19) Flag updates before a return are visible right after it.
// (R20) Dual-half bit 7, reset 0, selects two 16-bit ops in compat mode.
// (R21) Compat mode bit 5 of status one, resets to 1.
// (R22) Software never changes compat mode inside or beside a loop start.
// (R23) Reset: test flags 1, field 0, loop and dual 0, compat 1.
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH
`define DSM_ADDR_ONE_NATIVE 23'h000003
`define DSM_ADDR_ONE_ALIAS 23'h000007
`define DSM_ADDR_ZERO 23'h000002
`define DSM_BIT_TF1 13
`define DSM_BIT_TF2 12
`define DSM_BIT_LOOP 15
`define DSM_BIT_DUAL 7
`define DSM_BIT_COMPAT 5
`define DSM_FLD_SHIFT_HI 4
`define DSM_SHIFT_CNT_HI 5
`define DSM_RST_TF 1'b1
`define DSM_RST_SHIFT 5'h00
`define DSM_RST_LOOP 1'b0
`define DSM_RST_DUAL 1'b0
`define DSM_RST_COMPAT 1'b1
`define DSM_RST_CNT 16'h0000
`define DSM_RST_TMP 16'h0000
`define DSM_RST_WORD 16'h0000
`endif

// file: dsm_pkg.sv
package dsm_pkg;
    typedef enum logic [1:0] {
        DSM_IDLE = 2'b00,
        DSM_LOOP = 2'b01,
        DSM_DRAIN = 2'b10
    } dsm_loop_state_t;
    typedef enum logic [2:0] {
        DSM_BIT_NONE = 3'b000,
        DSM_BIT_TF1_SEL = 3'b001,
        DSM_BIT_TF2_SEL = 3'b010,
        DSM_BIT_LOOP_SEL = 3'b011,
        DSM_BIT_DUAL_SEL = 3'b100,
        DSM_BIT_COMPAT_SEL = 3'b101
    } dsm_bit_sel_t;
endpackage : dsm_pkg

// file: dsm_shift_link.sv
`timescale 1ns/100ps
`include "dsm_regs.svh"
module dsm_shift_link
    import dsm_pkg::*;
(
    input wire logic [4:0] aliasField,
    input wire logic [15:0] tempIn,
    output logic [15:0] signExt,
    output logic [4:0] tempLow
);
    always_comb begin
        signExt = {{11{aliasField[`DSM_FLD_SHIFT_HI]}}, aliasField}; // [R3]
        tempLow = tempIn[`DSM_FLD_SHIFT_HI:0]; // [R5]
    end
endmodule : dsm_shift_link

// file: dsm_loop_ctl.sv
`timescale 1ns/100ps
`include "dsm_regs.svh"
module dsm_loop_ctl
    import dsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic loopFlag,
    input wire logic [15:0] cntIn,
    input wire logic lastDecode,
    output logic repeatPass,
    output logic [15:0] cntDec,
    output logic clrPend
);
    typedef struct packed {
        logic pend;
    } dsm_lc_t;
    dsm_lc_t st_ff;
    dsm_lc_t nxt_st;
    always_comb begin
        nxt_st = st_ff;
        repeatPass = lastDecode && loopFlag && (cntIn != `DSM_RST_CNT); // [R10]
        cntDec = cntIn - 16'h0001;
        nxt_st.pend = repeatPass && (cntDec == `DSM_RST_CNT); // [R11]
        clrPend = st_ff.pend;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : dsm_loop_ctl

// file: dsm_status_bits.sv
`timescale 1ns/100ps
`include "dsm_regs.svh"
module dsm_status_bits
    import dsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic memWrEn,
    input wire logic [22:0] memAddr,
    input wire logic [15:0] memWrData,
    input wire logic [22:0] memRdAddr,
    output logic [15:0] memRdData,
    input wire logic testUpdEn,
    input wire logic testSelTwo,
    input wire logic testResult,
    input wire logic bitSetEn,
    input wire logic bitClrEn,
    input wire logic [2:0] bitSel,
    input wire logic tempTwoWrEn,
    input wire logic [15:0] tempTwoWrData,
    input wire logic cntWrEn,
    input wire logic [15:0] cntWrData,
    input wire logic blockRepeatAddr,
    input wire logic lastInstrDecode,
    input wire logic farFlowExec,
    input wire logic intrEntry,
    input wire logic intrReturn,
    input wire logic [15:0] restoreData,
    input wire logic useFieldShift,
    input wire logic [4:0] instrShift,
    output logic [15:0] saveData,
    output logic [15:0] tempTwo,
    output logic [15:0] repeatCount,
    output logic [5:0] shiftCount,
    output logic repeatPass,
    output logic loopRunning,
    output logic dualHalfOp,
    output logic testFlagOne,
    output logic testFlagTwo,
    output logic [15:0] statusOne
);
    typedef struct packed {
        logic tf1;
        logic tf2;
        logic [4:0] shiftFld;
        logic loopFlag;
        logic dual;
        logic compat;
        logic [15:0] tmpTwo;
        logic [15:0] cnt;
        logic [15:0] zeroOther;
        logic [15:0] oneOther;
        logic [15:0] saved;
    } dsm_state_t;
    dsm_state_t st_ff;
    dsm_state_t nxt_st;
    logic [15:0] signExt;
    logic [4:0] tempLow;
    logic [15:0] cntDec;
    logic clrPend;
    logic wrAlias;
    logic wrNative;
    logic wrZero;
    logic newCompat;

    function automatic logic hitAddr(input logic [22:0] a,
                                     input logic [22:0] b);
        hitAddr = (a == b);
    endfunction : hitAddr

    function automatic logic [15:0] packOne(input dsm_state_t s);
        logic [15:0] v;
        v = s.oneOther;
        v[`DSM_BIT_LOOP] = s.loopFlag;
        v[`DSM_BIT_DUAL] = s.dual;
        v[`DSM_BIT_COMPAT] = s.compat;
        v[`DSM_FLD_SHIFT_HI:0] = s.shiftFld;
        packOne = v;
    endfunction : packOne

    function automatic logic [15:0] packZero(input dsm_state_t s);
        logic [15:0] v;
        v = s.zeroOther;
        v[`DSM_BIT_TF1] = s.tf1;
        v[`DSM_BIT_TF2] = s.tf2;
        packZero = v;
    endfunction : packZero

    dsm_shift_link u_link (
        .aliasField(memWrData[`DSM_FLD_SHIFT_HI:0]),
        .tempIn(tempTwoWrData),
        .signExt(signExt),
        .tempLow(tempLow)
    );

    dsm_loop_ctl u_loop (
        .ref_clk(ref_clk),
        .srst(srst),
        .loopFlag(st_ff.loopFlag),
        .cntIn(st_ff.cnt),
        .lastDecode(lastInstrDecode),
        .repeatPass(repeatPass),
        .cntDec(cntDec),
        .clrPend(clrPend)
    );

    always_comb begin
        wrAlias = memWrEn && hitAddr(memAddr, `DSM_ADDR_ONE_ALIAS); // [R2]
        wrNative = memWrEn && hitAddr(memAddr, `DSM_ADDR_ONE_NATIVE); // [R2]
        wrZero = memWrEn && hitAddr(memAddr, `DSM_ADDR_ZERO);
        newCompat = (wrAlias || wrNative) ? memWrData[`DSM_BIT_COMPAT]
                                          : st_ff.compat;
        nxt_st = st_ff;
        // Test flag updates from test instructions
        if (testUpdEn && !testSelTwo) begin
            nxt_st.tf1 = testResult; // [R1]
        end
        if (testUpdEn && testSelTwo) begin
            nxt_st.tf2 = testResult; // [R1]
        end
        if (wrZero) begin
            nxt_st.zeroOther = memWrData;
            nxt_st.tf1 = memWrData[`DSM_BIT_TF1]; // [R1]
            nxt_st.tf2 = memWrData[`DSM_BIT_TF2]; // [R1]
        end
        // Temp two loads; compat mode ties low bits to field
        if (tempTwoWrEn) begin
            nxt_st.tmpTwo = tempTwoWrData;
            if (st_ff.compat) begin
                nxt_st.shiftFld = tempLow; // [R5] [R6]
            end
        end
        // Loop control: decrement on pass, auto clear one cycle later
        if (cntWrEn) begin
            nxt_st.cnt = cntWrData;
        end else if (repeatPass) begin
            nxt_st.cnt = cntDec; // [R10]
        end
        if (clrPend) begin
            nxt_st.loopFlag = 1'b0; // [R11]
        end
        if (cntWrEn && cntWrData == `DSM_RST_CNT) begin
            nxt_st.loopFlag = 1'b0; // [R11]
        end
        if (farFlowExec) begin
            nxt_st.loopFlag = 1'b0; // [R12]
        end
        if (blockRepeatAddr) begin
            nxt_st.loopFlag = 1'b1; // [R9]
        end
        if (bitSetEn || bitClrEn) begin
            case (bitSel)
                DSM_BIT_TF1_SEL: nxt_st.tf1 = bitSetEn; // [R1]
                DSM_BIT_TF2_SEL: nxt_st.tf2 = bitSetEn; // [R1]
                DSM_BIT_LOOP_SEL: nxt_st.loopFlag = bitSetEn; // [R13]
                DSM_BIT_DUAL_SEL: nxt_st.dual = bitSetEn; // [R20]
                DSM_BIT_COMPAT_SEL: nxt_st.compat = bitSetEn; // [R21]
                default: nxt_st.oneOther = st_ff.oneOther;
            endcase
        end
        // Interrupt context: save and restore status one
        if (intrEntry) begin
            nxt_st.saved = packOne(st_ff); // [R14]
        end
        if (intrReturn) begin
            nxt_st.loopFlag = restoreData[`DSM_BIT_LOOP]; // [R14] [R19]
            nxt_st.dual = restoreData[`DSM_BIT_DUAL];
            nxt_st.compat = restoreData[`DSM_BIT_COMPAT];
            nxt_st.shiftFld = restoreData[`DSM_FLD_SHIFT_HI:0];
            nxt_st.oneOther = restoreData;
        end
        // Status one writes win; new compat state governs this write
        if (wrAlias || wrNative) begin
            nxt_st.oneOther = memWrData;
            nxt_st.loopFlag = memWrData[`DSM_BIT_LOOP]; // [R13] [R15]
            nxt_st.dual = memWrData[`DSM_BIT_DUAL]; // [R20]
            nxt_st.compat = memWrData[`DSM_BIT_COMPAT]; // [R21]
            nxt_st.shiftFld = memWrData[`DSM_FLD_SHIFT_HI:0];
            if (wrAlias && newCompat) begin
                nxt_st.tmpTwo = signExt; // [R3] [R7] [R6]
            end
        end
        if (srst) begin
            nxt_st.tf1 = `DSM_RST_TF; // [R23]
            nxt_st.tf2 = `DSM_RST_TF;
            nxt_st.shiftFld = `DSM_RST_SHIFT;
            nxt_st.loopFlag = `DSM_RST_LOOP;
            nxt_st.dual = `DSM_RST_DUAL;
            nxt_st.compat = `DSM_RST_COMPAT;
            nxt_st.tmpTwo = `DSM_RST_TMP;
            nxt_st.cnt = `DSM_RST_CNT;
            nxt_st.zeroOther = `DSM_RST_WORD;
            nxt_st.oneOther = `DSM_RST_WORD;
            nxt_st.saved = `DSM_RST_WORD;
        end
    end

    always_ff @(posedge ref_clk) begin
        st_ff <= nxt_st;
    end

    always_comb begin
        statusOne = packOne(st_ff);
        if (hitAddr(memRdAddr, `DSM_ADDR_ONE_ALIAS) ||
            hitAddr(memRdAddr, `DSM_ADDR_ONE_NATIVE)) begin
            memRdData = statusOne; // [R2]
        end else if (hitAddr(memRdAddr, `DSM_ADDR_ZERO)) begin
            memRdData = packZero(st_ff);
        end else begin
            memRdData = 16'h0000;
        end
        // Field count only in compat mode, else instruction count
        if (st_ff.compat && useFieldShift) begin
            shiftCount = st_ff.tmpTwo[`DSM_SHIFT_CNT_HI:0]; // [R4]
        end else begin
            shiftCount = {1'b0, instrShift}; // [R6]
        end
        saveData = st_ff.saved;
        tempTwo = st_ff.tmpTwo;
        repeatCount = st_ff.cnt;
        loopRunning = st_ff.compat && st_ff.loopFlag; // [R8]
        dualHalfOp = st_ff.compat && st_ff.dual; // [R20]
        testFlagOne = st_ff.tf1;
        testFlagTwo = st_ff.tf2;
    end
endmodule : dsm_status_bits

// file: dsm_status_bits_properties.sv
`timescale 1ns/100ps
module dsm_status_bits_properties (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic memWrEn,
    input wire logic [22:0] memAddr,
    input wire logic [15:0] memWrData,
    input wire logic tempTwoWrEn,
    input wire logic cntWrEn,
    input wire logic [15:0] cntWrData,
    input wire logic blockRepeatAddr,
    input wire logic lastInstrDecode,
    input wire logic farFlowExec,
    input wire logic bitSetEn,
    input wire logic bitClrEn,
    input wire logic intrReturn,
    input wire logic [15:0] tempTwo,
    input wire logic [15:0] repeatCount,
    input wire logic repeatPass,
    input wire logic dualHalfOp,
    input wire logic [15:0] statusOne
);
    logic [15:0] wrData_ff;
    logic quiet;
    // No memory write, bit set/clear, return or block-repeat start in this cycle
    assign quiet = !(memWrEn || bitSetEn || bitClrEn || intrReturn
        || blockRepeatAddr);
    always_ff @(posedge ref_clk) begin
        wrData_ff <= memWrData;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_reset_state: assert property (
        $fell(srst) |-> statusOne == 16'h0020) else $error("reset");
    a_loop_set: assert property (
        blockRepeatAddr && !(memWrEn || bitClrEn || intrReturn)
        |=> statusOne[15]) else $error("loop set");
    a_far_clear: assert property (
        farFlowExec && quiet |=> !statusOne[15]) else $error("far");
    a_zero_clear: assert property (
        cntWrEn && cntWrData == 16'h0000 && quiet ##1 quiet
        |=> !statusOne[15]) else $error("zero write");
    a_pass_rule: assert property (
        lastInstrDecode && statusOne[5] |-> repeatPass ==
        (statusOne[15] && repeatCount != 16'h0000)) else $error("pass");
    a_count_dec: assert property (
        repeatPass && !cntWrEn |=> repeatCount == $past(repeatCount)
        - 16'h0001) else $error("count");
    a_last_clear: assert property (
        repeatPass && repeatCount == 16'h0001 && !cntWrEn ##1 quiet
        |=> !statusOne[15]) else $error("drain");
    a_alias_sext: assert property (
        memWrEn && memAddr == 23'h000007 && memWrData[5] |=>
        tempTwo == {{11{wrData_ff[4]}}, wrData_ff[4:0]}) else $error("sext");
    a_alias_keep: assert property (
        memWrEn && memAddr == 23'h000007 && !memWrData[5] && !tempTwoWrEn
        |=> $stable(tempTwo)) else $error("keep");
    a_dual_mode: assert property (
        dualHalfOp == (statusOne[7] && statusOne[5])) else $error("dual");
endmodule : dsm_status_bits_properties
bind dsm_status_bits dsm_status_bits_properties u_dsm_status_bits_properties (
    .ref_clk, .srst, .memWrEn, .memAddr, .memWrData, .tempTwoWrEn, .cntWrEn,
    .cntWrData, .blockRepeatAddr, .lastInstrDecode, .farFlowExec, .bitSetEn,
    .bitClrEn, .intrReturn, .tempTwo, .repeatCount, .repeatPass, .dualHalfOp,
    .statusOne);

// file: dsm_status_bits_tb_top.sv
`timescale 1ns/100ps
`include "dsm_regs.svh"
module dsm_status_bits_tb_top
    import dsm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst, memWrEn, testUpdEn, testSelTwo, testResult, bitSetEn;
    logic bitClrEn, tempTwoWrEn, cntWrEn, blockRepeatAddr, lastInstrDecode;
    logic farFlowExec, intrEntry, intrReturn, useFieldShift, repeatPass;
    logic loopRunning, dualHalfOp, testFlagOne, testFlagTwo, passSeen;
    logic [2:0] bitSel;
    logic [4:0] instrShift;
    logic [5:0] shiftCount;
    logic [9:0] ctl;
    logic [15:0] memWrData, memRdData, tempTwoWrData, cntWrData, restoreData;
    logic [15:0] saveData, tempTwo, repeatCount, statusOne;
    logic [22:0] memAddr, memRdAddr;
    int errorCnt, totalChecks;
    localparam logic [9:0] TST = 10'h200, SET = 10'h100, CLR = 10'h080;
    localparam logic [9:0] TMPW = 10'h040, CNT = 10'h020, RPT = 10'h010;
    localparam logic [9:0] LAST = 10'h008, FAR = 10'h004, ENT = 10'h002;
    localparam logic [9:0] RET = 10'h001;
    assign {testUpdEn, bitSetEn, bitClrEn, tempTwoWrEn, cntWrEn,
        blockRepeatAddr, lastInstrDecode, farFlowExec, intrEntry,
        intrReturn} = ctl;
    always #10 ref_clk = ~ref_clk;
    dsm_status_bits u_dsm_status_bits (.ref_clk, .srst, .memWrEn, .memAddr,
        .memWrData, .memRdAddr, .memRdData, .testUpdEn, .testSelTwo,
        .testResult, .bitSetEn, .bitClrEn, .bitSel, .tempTwoWrEn,
        .tempTwoWrData, .cntWrEn, .cntWrData, .blockRepeatAddr,
        .lastInstrDecode, .farFlowExec, .intrEntry, .intrReturn, .restoreData,
        .useFieldShift, .instrShift, .saveData, .tempTwo, .repeatCount,
        .shiftCount, .repeatPass, .loopRunning, .dualHalfOp, .testFlagOne,
        .testFlagTwo, .statusOne);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [22:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        memWrEn <= 1'b1;
        memAddr <= a;
        memWrData <= d;
        @(posedge ref_clk);
        memWrEn <= 1'b0;
        @(negedge ref_clk);
    endtask : wr
    task rd(input logic [22:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        memRdAddr <= a;
        @(negedge ref_clk);
        chk(memRdData, e);
    endtask : rd
    // One-cycle strobes; repeat decision caught while the strobe is up
    task pulse(input logic [9:0] m, input logic [15:0] d, input logic [2:0] s);
        @(posedge ref_clk);
        ctl <= m;
        {tempTwoWrData, cntWrData, restoreData} <= {3{d}};
        {testSelTwo, testResult} <= d[1:0];
        bitSel <= s;
        @(negedge ref_clk);
        passSeen = repeatPass;
        @(posedge ref_clk);
        ctl <= 10'h000;
        @(negedge ref_clk);
    endtask : pulse
    task endOfTest;
        $display("Checks %0d, errors %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : endOfTest
    initial begin
        {memWrEn, testSelTwo, testResult, bitSel, instrShift, ctl} = '0;
        {memWrData, tempTwoWrData, cntWrData, restoreData} = '0;
        {memAddr, memRdAddr} = '0;
        srst = 1'b1;
        useFieldShift = 1'b1;
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        rd(`DSM_ADDR_ONE_NATIVE, 16'h0020);
        rd(`DSM_ADDR_ONE_ALIAS, 16'h0020);
        rd(`DSM_ADDR_ZERO, 16'h3000);
        rd(23'h000010, 16'h0000);
        pulse(TST, 16'h0002, 3'h0);
        chk({14'h0, testFlagOne, testFlagTwo}, 16'h0002);
        pulse(TST, 16'h0000, 3'h0);
        chk({14'h0, testFlagOne, testFlagTwo}, 16'h0000);
        pulse(SET, 16'h0000, DSM_BIT_TF2_SEL);
        rd(`DSM_ADDR_ZERO, 16'h1000);
        wr(`DSM_ADDR_ONE_ALIAS, 16'h003a);
        chk(tempTwo, 16'hfffa);
        wr(`DSM_ADDR_ONE_NATIVE, 16'h0000);
        wr(`DSM_ADDR_ONE_ALIAS, 16'h0013);
        chk(tempTwo, 16'hfffa);
        pulse(TMPW, 16'h1234, 3'h0);
        rd(`DSM_ADDR_ONE_ALIAS, 16'h0013);
        wr(`DSM_ADDR_ONE_ALIAS, 16'h0031);
        chk(tempTwo, 16'hfff1);
        pulse(TMPW, 16'h0abc, 3'h0);
        chk(statusOne, 16'h003c);
        chk({10'h0, shiftCount}, 16'h003c);
        pulse(RPT | CNT, 16'h0002, 3'h0);
        chk(statusOne, 16'h803c);
        chk({15'h0, loopRunning}, 16'h0001);
        pulse(LAST, 16'h0000, 3'h0);
        chk({passSeen, repeatCount[14:0]}, 16'h8001);
        pulse(LAST, 16'h0000, 3'h0);
        chk({passSeen, repeatCount[14:0]}, 16'h8000);
        pulse(LAST, 16'h0000, 3'h0);
        chk({passSeen, statusOne[14:0]}, 16'h003c);
        pulse(RPT, 16'h0000, 3'h0);
        pulse(CNT, 16'h0000, 3'h0);
        pulse(10'h000, 16'h0000, 3'h0);
        chk(statusOne, 16'h003c);
        chk({15'h0, loopRunning}, 16'h0000);
        pulse(RPT, 16'h0000, 3'h0);
        pulse(FAR, 16'h0000, 3'h0);
        chk(statusOne, 16'h003c);
        pulse(RPT, 16'h0000, 3'h0);
        pulse(ENT, 16'h0000, 3'h0);
        chk(saveData, 16'h803c);
        chk(statusOne, 16'h803c);
        pulse(CLR, 16'h0000, DSM_BIT_LOOP_SEL);
        chk(statusOne, 16'h003c);
        wr(`DSM_ADDR_ONE_NATIVE, 16'h0000);
        wr(`DSM_ADDR_ONE_NATIVE, 16'h8020);
        chk(statusOne, 16'h8020);
        chk({15'h0, loopRunning}, 16'h0001);
        pulse(RET, 16'h00a0, 3'h0);
        chk(statusOne, 16'h00a0);
        chk({15'h0, dualHalfOp}, 16'h0001);
        pulse(CLR, 16'h0000, DSM_BIT_COMPAT_SEL);
        chk({15'h0, dualHalfOp}, 16'h0000);
        @(posedge ref_clk);
        instrShift <= 5'h15;
        @(negedge ref_clk);
        chk({10'h0, shiftCount}, 16'h0015);
        endOfTest;
    end
    initial begin
        repeat (2000) @(posedge ref_clk);
        errorCnt++;
        endOfTest;
    end
endmodule : dsm_status_bits_tb_top
